// File: shared/hspc_regs.vh
`ifndef HSPC_REGS_VH
`define HSPC_REGS_VH
`define HSPC_CLK_MHZ 100
`define HSPC_CLK_HZ 32'h05F5E100
`define HSPC_A_CTRL 4'h0
`define HSPC_A_COUNT 4'h1
`define HSPC_A_TARGET 4'h2
`define HSPC_A_CAP0 4'h3
`define HSPC_A_CAP1 4'h4
`define HSPC_A_PERIOD 4'h5
`define HSPC_A_FREQ 4'h6
`define HSPC_A_STAT 4'h7
`define HSPC_A_MASK 4'h8
`define HSPC_A_IRQID 4'h9
`define HSPC_F_MODE 1:0
`define HSPC_F_MULT 3:2
`define HSPC_F_RING 4
`define HSPC_F_FILT 7:5
`define HSPC_F_CSEL 8
`define HSPC_F_CEDGE 9
`define HSPC_F_EN 10
`define HSPC_CTRL_RST 11'h000
`define HSPC_MODE_SINGLE 2'h0
`define HSPC_MODE_PDIR 2'h1
`define HSPC_MODE_QUAD 2'h2
`define HSPC_MULT_X1 2'h0
`define HSPC_MULT_X2 2'h1
`define HSPC_MULT_X4 2'h2
`define HSPC_S_MATCH 0
`define HSPC_S_CAP0 1
`define HSPC_S_CAP1 2
`define HSPC_S_INT0 3
`define HSPC_S_INT1 4
`define HSPC_S_FREQ 5
`define HSPC_NSTAT 6
`define HSPC_CNT_MAX 32'h7FFFFFFF
`define HSPC_CNT_MIN 32'h80000000
`define HSPC_TF1_NS 100
`define HSPC_TF2_NS 200
`define HSPC_TF3_NS 500
`define HSPC_TF4_NS 1000
`define HSPC_TF5_NS 2000
`define HSPC_TF6_NS 10000
`define HSPC_NS2CYC(ns) (((ns) * `HSPC_CLK_MHZ + 999) / 1000)
`endif

// File: core/hspc_filt.v
`timescale 1ns/1ps
`include "hspc_regs.vh"
module hspc_filt (
    input wire ref_clk_i, // System clock.
    input wire rst_i, // Synchronous reset.
    input wire [3:0] raw_i, // Raw inputs.
    input wire [2:0] sel_i, // Filter constant select.
    output reg [3:0] filt_o // Filtered inputs.
);
    reg [3:0] s1_q;
    reg [3:0] s2_q;
    reg [9:0] cnt_q [0:3];
    reg [9:0] lim;
    integer i;

    function [9:0] lim_of;
        input [2:0] sel;
        reg [31:0] cyc;
        begin
            case (sel)
                3'h1: cyc = `HSPC_NS2CYC(`HSPC_TF1_NS);
                3'h2: cyc = `HSPC_NS2CYC(`HSPC_TF2_NS);
                3'h3: cyc = `HSPC_NS2CYC(`HSPC_TF3_NS);
                3'h4: cyc = `HSPC_NS2CYC(`HSPC_TF4_NS);
                3'h5: cyc = `HSPC_NS2CYC(`HSPC_TF5_NS);
                3'h6: cyc = `HSPC_NS2CYC(`HSPC_TF6_NS);
                default: cyc = 32'h00000000;
            endcase
            lim_of = cyc[9:0];
        end
    endfunction

    always @* begin
        lim = lim_of(sel_i);
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            filt_o <= 4'h0;
            for (i = 0; i < 4; i = i + 1) cnt_q[i] <= 10'h000;
        end else begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            for (i = 0; i < 4; i = i + 1) begin
                if (s2_q[i] == filt_o[i]) begin
                    cnt_q[i] <= 10'h000;
                end else if (cnt_q[i] + 10'h001 >= lim) begin
                    filt_o[i] <= s2_q[i];
                    cnt_q[i] <= 10'h000;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 10'h001;
                end
            end
        end
    end
endmodule // hspc_filt

// File: core/hspc_div.v
`timescale 1ns/1ps
`include "hspc_regs.vh"
module hspc_div (
    input wire ref_clk_i, // System clock.
    input wire rst_i, // Synchronous reset.
    input wire start_i, // Start pulse.
    input wire [31:0] period_i, // Cycles per count change.
    output wire busy_o, // Division running.
    output reg done_o, // Result pulse.
    output reg [31:0] freq_o // Frequency in Hz.
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    reg st_q;
    reg [4:0] bit_q;
    reg [31:0] dvs_q;
    reg [31:0] quo_q;
    reg [32:0] rem_q;
    wire [31:0] hz = `HSPC_CLK_HZ;
    wire quo_bit_in = hz[bit_q];
    wire [32:0] shr = {rem_q[31:0], quo_bit_in};
    wire ge = shr >= {1'b0, dvs_q};

    assign busy_o = st_q;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            bit_q <= 5'h00;
            dvs_q <= 32'h0;
            quo_q <= 32'h0;
            rem_q <= 33'h0;
            done_o <= 1'b0;
            freq_o <= 32'h0;
        end else begin
            done_o <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (start_i) begin
                        st_q <= ST_RUN;
                        bit_q <= 5'h1F;
                        dvs_q <= period_i;
                        quo_q <= 32'h0;
                        rem_q <= 33'h0;
                    end
                end
                ST_RUN: begin
                    rem_q <= ge ? shr - {1'b0, dvs_q} : shr;
                    quo_q <= {quo_q[30:0], ge};
                    bit_q <= bit_q - 5'h01;
                    if (bit_q == 5'h00) begin
                        st_q <= ST_IDLE;
                        done_o <= 1'b1;
                        freq_o <= (dvs_q == 32'h0) ? 32'hFFFFFFFF : {quo_q[30:0], ge};
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // hspc_div

// File: core/hspc_top.v
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "hspc_regs.vh"
// Overview of operation
// - Single pulse counts one or both edges.
// - Pulse plus direction, edges one or two.
// - Quadrature counts at one, two or four.
// - Frequency from interval between count changes.
// - Target match sets or resets output by direction.
// - Match result drives an external pin.
// - Selected input edge captures count, register zero/one.
// - New capture always overwrites, no history.
// - Two control inputs, two external outputs.
// - Two interrupt inputs per channel, eight unit.
// - Lowest pending interrupt bit is served first.
// - Count is signed 32-bit two's complement.
// - Linear counter stops, ring counter wraps.
// - Inputs filtered with selectable time constant.
module hspc_top (
    input wire ref_clk_i, // System clock, 100 MHz.
    input wire rst_i, // Synchronous reset, active high.
    input wire phase_a_i, // Count input A.
    input wire phase_b_i, // Count input B or direction.
    input wire [1:0] ctl_in_i, // Control signal inputs.
    input wire [5:0] avs_address_i, // Avalon byte address.
    input wire avs_read_i, // Avalon read.
    input wire avs_write_i, // Avalon write.
    input wire [31:0] avs_writedata_i, // Avalon write data.
    output wire [31:0] avs_readdata_o, // Avalon read data.
    output wire avs_waitrequest_o, // Avalon wait request.
    output wire irq_o, // Level interrupt.
    output wire [1:0] ext_out_o // Match output, equal flag.
);
    reg ack_q;
    reg [31:0] rdata_q;
    reg [10:0] ctrl_q;
    reg signed [31:0] count_q;
    reg [31:0] target_q;
    reg [31:0] cap0_q;
    reg [31:0] cap1_q;
    reg [31:0] per_cnt_q;
    reg [31:0] period_q;
    reg [`HSPC_NSTAT-1:0] stat_q;
    reg [`HSPC_NSTAT-1:0] mask_q;
    reg cmp_q;
    reg eq_q;
    reg [3:0] prev_q;
    reg div_go_q;
    reg [31:0] count_d;
    reg cnt_en;
    reg cnt_up;
    reg [31:0] rd_mux;
    reg [`HSPC_NSTAT-1:0] ev;
    wire [3:0] filt;
    wire div_busy;
    wire div_done;
    wire [31:0] freq;

    wire req = avs_read_i | avs_write_i;
    wire [3:0] widx = avs_address_i[5:2];
    wire wr_en = avs_write_i & ack_q;
    wire [1:0] mode = ctrl_q[`HSPC_F_MODE];
    wire [1:0] mult = ctrl_q[`HSPC_F_MULT];
    wire a_f = filt[0];
    wire b_f = filt[1];
    wire [3:0] rises;
    wire [3:0] falls;
    wire a_r = rises[0];
    wire a_e = a_f ^ prev_q[0];
    wire b_e = b_f ^ prev_q[1];
    wire [1:0] ctl_r = rises[3:2];
    wire [1:0] ctl_fl = falls[3:2];
    wire cap_ev = ctrl_q[`HSPC_F_CEDGE] ? ctl_fl[0] : ctl_r[0];
    wire cnt_chg = cnt_en & (count_d != count_q);
    wire [`HSPC_NSTAT-1:0] pend = stat_q & mask_q;

    hspc_filt u_filt (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .raw_i({ctl_in_i, phase_b_i, phase_a_i}),
        .sel_i(ctrl_q[`HSPC_F_FILT]),
        .filt_o(filt)
    );

    hspc_div u_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(div_go_q),
        .period_i(period_q),
        .busy_o(div_busy),
        .done_o(div_done),
        .freq_o(freq)
    );

    // True when a write in its taken cycle addresses the given word.
    function wr_hit;
        input en;
        input [3:0] idx;
        input [3:0] word;
        begin
            wr_hit = en & (idx == word);
        end
    endfunction

    // Bits that are high now and were low in the previous sample.
    function [3:0] rise_of;
        input [3:0] cur;
        input [3:0] prv;
        begin
            rise_of = cur & ~prv;
        end
    endfunction

    // Returns a valid flag and the index of the lowest pending bit.
    function [3:0] lowest;
        input [`HSPC_NSTAT-1:0] p;
        integer k;
        begin
            lowest = 4'h0;
            for (k = `HSPC_NSTAT - 1; k >= 0; k = k - 1) begin
                if (p[k]) begin
                    lowest = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o = rdata_q;
    assign irq_o = |pend;
    assign ext_out_o = {eq_q, cmp_q};
    assign rises = rise_of(filt, prev_q);
    assign falls = rise_of(prev_q, filt);

    // Count decode for the selected input type and multiplication.
    always @* begin
        cnt_en = 1'b0;
        cnt_up = 1'b1;
        case (mode)
            `HSPC_MODE_SINGLE: begin
                cnt_en = (mult == `HSPC_MULT_X1) ? a_r : a_e;
                cnt_up = 1'b1;
            end
            `HSPC_MODE_PDIR: begin
                cnt_en = (mult == `HSPC_MULT_X1) ? a_r : a_e;
                cnt_up = ~b_f;
            end
            `HSPC_MODE_QUAD: begin
                case (mult)
                    `HSPC_MULT_X1: begin
                        cnt_en = a_r;
                        cnt_up = ~b_f;
                    end
                    `HSPC_MULT_X2: begin
                        cnt_en = a_e;
                        cnt_up = a_f ^ b_f;
                    end
                    default: begin
                        // Both phases moving at once is illegal and not counted.
                        cnt_en = a_e ^ b_e;
                        cnt_up = a_e ? (a_f ^ b_f) : ~(a_f ^ b_f);
                    end
                endcase
            end
            default: begin
                cnt_en = 1'b0;
                cnt_up = 1'b1;
            end
        endcase
        cnt_en = cnt_en & ctrl_q[`HSPC_F_EN];
    end

    always @* begin
        count_d = count_q;
        if (cnt_up) begin
            if (count_q == `HSPC_CNT_MAX) begin
                count_d = ctrl_q[`HSPC_F_RING] ? `HSPC_CNT_MIN : `HSPC_CNT_MAX;
            end else begin
                count_d = count_q + 32'h1;
            end
        end else begin
            if (count_q == `HSPC_CNT_MIN) begin
                count_d = ctrl_q[`HSPC_F_RING] ? `HSPC_CNT_MAX : `HSPC_CNT_MIN;
            end else begin
                count_d = count_q - 32'h1;
            end
        end
    end

    // Capture and interrupt events come from the filtered, synchronised control inputs.
    always @* begin
        ev = {`HSPC_NSTAT{1'b0}};
        ev[`HSPC_S_MATCH] = cnt_chg & (count_d == target_q);
        ev[`HSPC_S_CAP0] = cap_ev & ~ctrl_q[`HSPC_F_CSEL];
        ev[`HSPC_S_CAP1] = cap_ev & ctrl_q[`HSPC_F_CSEL];
        ev[`HSPC_S_INT0] = ctl_r[0];
        ev[`HSPC_S_INT1] = ctl_r[1];
        ev[`HSPC_S_FREQ] = div_done;
    end

    always @* begin
        case (widx)
            `HSPC_A_CTRL: rd_mux = {21'h0, ctrl_q};
            `HSPC_A_COUNT: rd_mux = count_q;
            `HSPC_A_TARGET: rd_mux = target_q;
            `HSPC_A_CAP0: rd_mux = cap0_q;
            `HSPC_A_CAP1: rd_mux = cap1_q;
            `HSPC_A_PERIOD: rd_mux = period_q;
            `HSPC_A_FREQ: rd_mux = freq;
            `HSPC_A_STAT: rd_mux = {26'h0, stat_q};
            `HSPC_A_MASK: rd_mux = {26'h0, mask_q};
            `HSPC_A_IRQID: rd_mux = {28'h0, lowest(pend)};
            default: rd_mux = 32'h0;
        endcase
    end

    // Bus slave: one wait cycle, read data loaded while waitrequest is high.
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read_i & ~ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q <= `HSPC_CTRL_RST;
            target_q <= 32'h0;
            mask_q <= {`HSPC_NSTAT{1'b0}};
            stat_q <= {`HSPC_NSTAT{1'b0}};
        end else begin
            if (wr_hit(wr_en, widx, `HSPC_A_CTRL)) begin
                ctrl_q <= avs_writedata_i[10:0];
            end
            if (wr_hit(wr_en, widx, `HSPC_A_TARGET)) begin
                target_q <= avs_writedata_i;
            end
            if (wr_hit(wr_en, widx, `HSPC_A_MASK)) begin
                mask_q <= avs_writedata_i[`HSPC_NSTAT-1:0];
            end
            // A new event wins over a write-one clear in the same cycle.
            if (wr_hit(wr_en, widx, `HSPC_A_STAT)) begin
                stat_q <= (stat_q & ~avs_writedata_i[`HSPC_NSTAT-1:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_q <= 32'h0;
            cap0_q <= 32'h0;
            cap1_q <= 32'h0;
            cmp_q <= 1'b0;
            eq_q <= 1'b0;
            prev_q <= 4'h0;
        end else begin
            prev_q <= filt;
            // The equal flag is a plain registered compare, so it is high right
            // after reset while count and target are both zero.
            eq_q <= (count_q == target_q);
            // A bus preset wins over a count edge in the same cycle, and the
            // captures below take the count from before that update.
            if (wr_hit(wr_en, widx, `HSPC_A_COUNT)) begin
                count_q <= avs_writedata_i;
            end else if (cnt_en) begin
                count_q <= count_d;
            end
            if (ev[`HSPC_S_MATCH]) begin
                cmp_q <= cnt_up;
            end
            if (ev[`HSPC_S_CAP0]) begin
                cap0_q <= count_q;
            end
            if (ev[`HSPC_S_CAP1]) begin
                cap1_q <= count_q;
            end
        end
    end

    // Interval timer between count changes feeding the divider.
    // The interval counter saturates, but period only loads on a count change, so a stopped input keeps its last rate, and
    // a change that comes while the divider is busy is not divided.
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            per_cnt_q <= 32'h0;
            period_q <= 32'h0;
            div_go_q <= 1'b0;
        end else begin
            div_go_q <= 1'b0;
            if (cnt_chg) begin
                per_cnt_q <= 32'h0;
                period_q <= per_cnt_q + 32'h1;
                div_go_q <= ~div_busy;
            end else if (per_cnt_q != 32'hFFFFFFFF) begin
                per_cnt_q <= per_cnt_q + 32'h1;
            end
        end
    end
endmodule // hspc_top

// File: test/hspc_enc_model.sv
`timescale 1ns/1ps
module hspc_enc_model (
    input wire clk_i, // System clock.
    output reg pa_o, // Phase A or pulse.
    output reg pb_o, // Phase B or direction.
    output reg [1:0] ctl_o // Control inputs.
);
    initial begin
        pa_o = 1'b0;
        pb_o = 1'b0;
        ctl_o = 2'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic setb(input bit v);
        pb_o <= v;
    endtask
    // Pulse train on A; the count changes every 2*w cycles at x1 and every w cycles at x2.
    task automatic pulse(input int n, input int w);
        repeat (n) begin
            pa_o <= 1'b1;
            hold(w);
            pa_o <= 1'b0;
            hold(w);
        end
    endtask
    // Gray steps; A leads B when counting up.
    task automatic quad(input int n, input bit up);
        repeat (n * 4) begin
            if (up ^ pa_o ^ pb_o) pa_o <= ~pa_o;
            else pb_o <= ~pb_o;
            hold(6);
        end
    endtask
    task automatic cset(input int i, input bit v);
        ctl_o[i] <= v;
        hold(8);
    endtask
    task automatic cpulse(input int i);
        cset(i, 1'b1);
        cset(i, 1'b0);
    endtask
endmodule // hspc_enc_model

// File: test/hspc_assertions.sv
`timescale 1ns/1ps
module hspc_assertions (
    input wire ref_clk_i, // System clock.
    input wire rst_i, // Synchronous reset.
    input wire [5:0] avs_address_i, // Byte address.
    input wire avs_read_i, // Read request.
    input wire avs_write_i, // Write request.
    input wire [31:0] avs_readdata_o, // Read data.
    input wire avs_waitrequest_o, // Wait request.
    input wire irq_o, // Level interrupt.
    input wire [1:0] ext_out_o // Match outputs.
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire req = avs_read_i | avs_write_i;
    wire take = req & ~avs_waitrequest_o;
    property p_wait_first;
        req && !$past(req) |-> avs_waitrequest_o;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no first wait cycle");
    property p_wait_one;
        req && avs_waitrequest_o |=> !avs_waitrequest_o || !req;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
    property p_wait_idle;
        !req |-> !avs_waitrequest_o;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
    property p_rst;
        @(posedge ref_clk_i) disable iff (1'b0)
        rst_i |=> !irq_o && ext_out_o == 2'h0 && avs_readdata_o == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_rd_stand;
        !avs_read_i |=> $stable(avs_readdata_o);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved without read");
    property p_unmapped;
        take && avs_read_i && avs_address_i[5:2] > 4'h9 |-> avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irqid;
        take && avs_read_i && avs_address_i[5:2] == 4'h9 |-> avs_readdata_o[3] == $past(irq_o);
    endproperty
    a_irqid: assert property (p_irqid) else $error("pending flag differs from irq");
    property p_irq_fall;
        $fell(irq_o) |-> $past(take && avs_write_i) || $past(rst_i);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule // hspc_assertions
bind hspc_top hspc_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .ext_out_o(ext_out_o));

// File: test/testbench.sv
`timescale 1ns/1ps
`include "hspc_regs.vh"
module testbench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] v;
    wire [31:0] rdata;
    wire wreq;
    wire irq;
    wire [1:0] xo;
    wire pa;
    wire pb;
    wire [1:0] ctl;
    int err_total = 0;
    int checked = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    hspc_enc_model enc (.clk_i(ref_clk_i), .pa_o(pa), .pb_o(pb), .ctl_o(ctl));
    hspc_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .phase_a_i(pa), .phase_b_i(pb),
        .ctl_in_i(ctl), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .irq_o(irq), .ext_out_o(xo));
    task automatic test_done();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic acc(input bit w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        rd <= !w;
        wr <= w;
        adr <= {a, 2'b00};
        wd <= d;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk_i);
        if (n >= 50) begin
            chk("bus timeout", 32'h0, 32'h1);
            test_done();
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, e, v);
    endtask
    task automatic pcase(input logic [31:0] c, input logic [31:0] p, input bit d, input int n,
        input logic [31:0] e);
        enc.setb(d);
        wrr(`HSPC_A_CTRL, c);
        wrr(`HSPC_A_COUNT, p);
        enc.pulse(n, 6);
        repeat (8) @(posedge ref_clk_i);
        rdc("count", `HSPC_A_COUNT, e);
    endtask
    task automatic t_reset();
        rdc("count", `HSPC_A_COUNT, 32'h0);
        rdc("cap0", `HSPC_A_CAP0, 32'h0);
        rdc("cap1", `HSPC_A_CAP1, 32'h0);
        chk("cmp_out", 32'h0, xo[0]);
        chk("eq_out", 32'h1, xo[1]);
        rdc("unmapped", 4'hF, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_count();
        pcase(32'h400, 32'h0, 1'b0, 5, 32'h5);
        pcase(32'h404, 32'h0, 1'b0, 5, 32'hA);
        pcase(32'h401, 32'h0, 1'b1, 3, 32'hFFFFFFFD);
        pcase(32'h405, 32'h0, 1'b1, 3, 32'hFFFFFFFA);
        pcase(32'h401, 32'h0, 1'b0, 2, 32'h2);
        pcase(32'h400, 32'h7FFFFFFE, 1'b0, 3, `HSPC_CNT_MAX);
        pcase(32'h410, 32'h7FFFFFFE, 1'b0, 3, 32'h80000001);
        pcase(32'h420, 32'h0, 1'b0, 3, 32'h0);
        $display("t_count done");
    endtask
    task automatic t_quad();
        for (int m = 0; m < 3; m++) begin
            wrr(`HSPC_A_CTRL, 32'h402 | (m << 2));
            wrr(`HSPC_A_COUNT, 32'h0);
            enc.quad(3, 1'b1);
            enc.quad(1, 1'b0);
            repeat (8) @(posedge ref_clk_i);
            rdc("quad", `HSPC_A_COUNT, 32'h2 << m);
        end
        $display("t_quad done");
    endtask
    task automatic t_match();
        wrr(`HSPC_A_STAT, 32'h3F);
        wrr(`HSPC_A_TARGET, 32'h5);
        pcase(32'h400, 32'h2, 1'b0, 3, 32'h5);
        chk("out_up", 32'h1, xo[0]);
        chk("eq_up", 32'h1, xo[1]);
        wrr(`HSPC_A_MASK, 32'h1);
        chk("irq_on", 32'h1, irq);
        wrr(`HSPC_A_STAT, 32'h1);
        chk("irq_off", 32'h0, irq);
        pcase(32'h401, 32'h7, 1'b1, 2, 32'h5);
        chk("out_dn", 32'h0, xo[0]);
        chk("irq_dn", 32'h1, irq);
        wrr(`HSPC_A_MASK, 32'h0);
        chk("irq_mask", 32'h0, irq);
        $display("t_match done");
    endtask
    task automatic t_cap();
        wrr(`HSPC_A_CTRL, 32'h400);
        wrr(`HSPC_A_COUNT, 32'hB);
        enc.cpulse(0);
        rdc("cap0", `HSPC_A_CAP0, 32'hB);
        wrr(`HSPC_A_COUNT, 32'h16);
        enc.cpulse(0);
        rdc("cap0_new", `HSPC_A_CAP0, 32'h16);
        wrr(`HSPC_A_CTRL, 32'h500);
        wrr(`HSPC_A_COUNT, 32'h21);
        enc.cpulse(0);
        rdc("cap1", `HSPC_A_CAP1, 32'h21);
        rdc("cap0_kept", `HSPC_A_CAP0, 32'h16);
        wrr(`HSPC_A_CTRL, 32'h600);
        wrr(`HSPC_A_COUNT, 32'h2C);
        enc.cset(0, 1'b1);
        rdc("cap0_rise", `HSPC_A_CAP0, 32'h16);
        wrr(`HSPC_A_COUNT, 32'h37);
        enc.cset(0, 1'b0);
        rdc("cap0_fall", `HSPC_A_CAP0, 32'h37);
        $display("t_cap done");
    endtask
    task automatic t_irq();
        wrr(`HSPC_A_STAT, 32'h3F);
        wrr(`HSPC_A_MASK, 32'h18);
        enc.cpulse(1);
        enc.cpulse(0);
        rdc("irqid", `HSPC_A_IRQID, 32'hB);
        wrr(`HSPC_A_STAT, 32'h8);
        rdc("irqid_next", `HSPC_A_IRQID, 32'hC);
        wrr(`HSPC_A_STAT, 32'h3F);
        chk("irq_clr", 32'h0, irq);
        $display("t_irq done");
    endtask
    task automatic t_freq();
        wrr(`HSPC_A_CTRL, 32'h400);
        wrr(`HSPC_A_STAT, 32'h3F);
        enc.pulse(4, 10);
        repeat (60) @(posedge ref_clk_i);
        rdc("period", `HSPC_A_PERIOD, 32'h14);
        rdc("freq", `HSPC_A_FREQ, `HSPC_CLK_HZ / 32'h14);
        rdc("stat", `HSPC_A_STAT, 32'h20);
        $display("t_freq done");
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_count();
        t_quad();
        t_match();
        t_cap();
        t_irq();
        t_freq();
        test_done();
    end
endmodule // testbench
